// ### core/hbpg_defines.vh
// constants and register map of the horizontal blanking pattern generator
// Behaviour
// R1 - blanking has no start polarity; only toggle positions against pixel count place it
// R2 - mask 1: phases one/three high, two/four low; mask 0: one/three/last low
// R3 - each vertical sequence keeps its own blanking settings; the active one applies
// R4 - software programs unused toggles to 8189, never 8190 or 8191
// R5 - six toggle positions; each match inverts the blanking output
// R6 - each toggle position is 13 bits, pixel 0 to 8189
// R7 - alternation setting is 3 bits, modes 0 through 7
// R8 - mode 0 applies all six even toggles on every line
// R9 - mode 1: toggles 1-2 on odd lines, 3-6 on even lines
// R10 - mode 2: toggles 1-2 on even lines, 3-6 on odd lines
// R11 - mode 3: even set on even lines, odd set on odd lines; no vertical hold
// R12 - odd set is shared storage, read as blanking toggles only in mode 3
// R13 - modes 4-7 build blanking from start, end, length, repeats and four toggles
// R14 - in modes 4-7 toggle five is the start and toggle six the end
// R15 - length is 13 bits, repeats 8 bits; used only in modes 4-7
// R16 - phases two and four are always inverses of one and three
// R17 - line parity from a line counter restarting each field, first line even
// R18 - blanking starts each line inactive and inverts at each enabled toggle match
`ifndef HBPG_DEFINES_VH
`define HBPG_DEFINES_VH
`define HBPG_NSEQ_W 2
`define HBPG_SLOT_W 4
`define HBPG_POS_W 13
`define HBPG_LINE_W 12
`define HBPG_REP_W 8
`define HBPG_ALT_W 3
// per sequence bank slots
`define HBPG_SLOT_MASK 4'h0
`define HBPG_SLOT_ALT 4'h1
`define HBPG_SLOT_EVEN1 4'h2
`define HBPG_SLOT_LEN 4'h8
`define HBPG_SLOT_REP 4'h9
`define HBPG_SLOT_ODD1 4'hA
// byte addresses
`define HBPG_BANK_LIMIT 12'h100
`define HBPG_ADDR_CTRL 12'h100
`define HBPG_ADDR_LINE_LEN 12'h104
`define HBPG_ADDR_FIELD_LINES 12'h108
`define HBPG_ADDR_STATUS 12'h10C
// control fields
`define HBPG_CTRL_EN 0
`define HBPG_CTRL_SEQ_LO 1
`define HBPG_CTRL_SEQ_HI 2
// reset values
`define HBPG_LINE_LEN_RST 13'h0800
`define HBPG_FIELD_LINES_RST 12'h100
`define HBPG_TOG_RST 13'h1FFD
// alternation modes
`define HBPG_ALT_NONE 3'h0
`define HBPG_ALT_ODD12 3'h1
`define HBPG_ALT_EVEN12 3'h2
`define HBPG_ALT_SPLIT 3'h3
`define HBPG_ALT_REPEAT 3'h4
`endif

// ### core/hbpg_top.v
// horizontal blanking pattern generator with APB register slave
`timescale 1ns/1ps
`include "hbpg_defines.vh"

module hbpg_top (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// ccd horizontal clocks and blanking
	output reg line_blank,
	output reg hclk_phase_one,
	output reg hclk_phase_two,
	output reg hclk_phase_three,
	output reg hclk_phase_four,
	output reg last_stage_hclk,
	output reg line_start,
	output reg field_start
);

	localparam MEM_DEPTH = 64;

	// settings store: bank per vertical sequence, sixteen slots each
	reg [`HBPG_POS_W-1:0] cfg_mem [0:MEM_DEPTH-1];

	// controls and the sequence applied to the current line
	reg ctrl_en_r;
	reg [`HBPG_NSEQ_W-1:0] ctrl_seq_r;
	reg [`HBPG_NSEQ_W-1:0] seq_r;
	reg [`HBPG_POS_W-1:0] line_len_r;
	reg [`HBPG_LINE_W-1:0] field_lines_r;

	// pixel and line counters
	reg [`HBPG_POS_W-1:0] pix_r;
	reg [`HBPG_LINE_W-1:0] line_r;

	// blanking and repeat pattern state
	reg blank_r;
	reg win_r;
	reg run_r;
	reg pbit_r;
	reg [`HBPG_POS_W-1:0] pos_r;
	reg [`HBPG_REP_W-1:0] cnt_r;

	// phase of the horizontal clocks, toggling every cycle while enabled
	reg phase_r;
	integer i;

	function [`HBPG_POS_W-1:0] fld;
		input [`HBPG_NSEQ_W-1:0] seq;
		input [`HBPG_SLOT_W-1:0] slot;
		begin
			fld = cfg_mem[{seq, slot}];
		end
	endfunction

	function [`HBPG_SLOT_W-1:0] slot_add;
		input [`HBPG_SLOT_W-1:0] base;
		input [2:0] ofs;
		begin
			slot_add = base + {1'b0, ofs};
		end
	endfunction

	// pixel zero opens every line; the blank state restarts from here
	function at_line_start;
		input [`HBPG_POS_W-1:0] pix;
		begin
			at_line_start = pix == 13'h0000;
		end
	endfunction

	// apb decode
	wire apb_setup = psel & ~penable;
	wire apb_write = psel & penable & pready & pwrite;
	wire in_bank = paddr < `HBPG_BANK_LIMIT;
	wire [5:0] mem_idx = paddr[7:2];
	wire addr_ok = in_bank | (paddr == `HBPG_ADDR_CTRL) | (paddr == `HBPG_ADDR_LINE_LEN) |
		(paddr == `HBPG_ADDR_FIELD_LINES) | (paddr == `HBPG_ADDR_STATUS);
	wire apb_err = ~addr_ok | (paddr[1:0] != 2'h0);

	// write strobes; an access that drew an error changes nothing
	wire wr_ok = apb_write & ~pslverr;
	wire wr_bank = wr_ok & in_bank;
	wire wr_ctrl = wr_ok & (paddr == `HBPG_ADDR_CTRL);
	wire wr_line_len = wr_ok & (paddr == `HBPG_ADDR_LINE_LEN);
	wire wr_field_lines = wr_ok & (paddr == `HBPG_ADDR_FIELD_LINES);

	// current sequence settings
	wire mask_pol = fld(seq_r, `HBPG_SLOT_MASK) != 13'h0000;
	// narrow settings live in full-width slots; only their own bits are used
	wire [`HBPG_POS_W-1:0] alt_slot = fld(seq_r, `HBPG_SLOT_ALT);
	wire [`HBPG_POS_W-1:0] rep_slot = fld(seq_r, `HBPG_SLOT_REP);
	wire [`HBPG_ALT_W-1:0] alt = alt_slot[`HBPG_ALT_W-1:0];
	wire [`HBPG_POS_W-1:0] rep_len = fld(seq_r, `HBPG_SLOT_LEN);
	wire [`HBPG_REP_W-1:0] rep_num = rep_slot[`HBPG_REP_W-1:0];
	wire [`HBPG_POS_W-1:0] rep_start = fld(seq_r, slot_add(`HBPG_SLOT_EVEN1, 3'h4));
	wire [`HBPG_POS_W-1:0] rep_end = fld(seq_r, slot_add(`HBPG_SLOT_EVEN1, 3'h5));
	wire repeat_mode = alt >= `HBPG_ALT_REPEAT;

	wire line_end = pix_r == (line_len_r - 13'h0001);
	wire field_end = line_r == (field_lines_r - 12'h001);
	wire odd_line = line_r[0]; // R17

	// toggle selection per alternation mode
	reg [5:0] tog_en;
	reg use_odd;
	always @* begin
		tog_en = 6'h00;
		use_odd = 1'b0;
		case (alt)
		`HBPG_ALT_NONE: begin
			// no alternation: the full even set on every line
			tog_en = 6'h3F; // R8
		end
		`HBPG_ALT_ODD12: begin
			if (odd_line)
				tog_en = 6'h03; // R9
			else
				tog_en = 6'h3C; // R9
		end
		`HBPG_ALT_EVEN12: begin
			if (odd_line)
				tog_en = 6'h3C; // R10
			else
				tog_en = 6'h03; // R10
		end
		`HBPG_ALT_SPLIT: begin
			// odd lines borrow the shared odd slots; vertical hold is lost on every line in this mode
			tog_en = 6'h3F; // R11
			use_odd = odd_line; // R12
		end
		default: begin
			// repeat modes place blanking from the pattern logic instead
			tog_en = 6'h00; // R13
		end
		endcase
	end

	// toggle matches against pixel count and pattern position
	reg [`HBPG_POS_W-1:0] pos_cur;
	reg start_hit;
	always @* begin
		start_hit = pix_r == rep_start; // R14
		pos_cur = start_hit ? 13'h0000 : pos_r;
	end

	// one comparator per toggle slot; an even number of matches cancels out
	wire [`HBPG_SLOT_W-1:0] bank_base = use_odd ? `HBPG_SLOT_ODD1 : `HBPG_SLOT_EVEN1;
	wire [5:0] tog_match;
	wire [3:0] pat_match;
	assign tog_match[0] = pix_r == fld(seq_r, slot_add(bank_base, 3'h0));
	assign tog_match[1] = pix_r == fld(seq_r, slot_add(bank_base, 3'h1));
	assign tog_match[2] = pix_r == fld(seq_r, slot_add(bank_base, 3'h2));
	assign tog_match[3] = pix_r == fld(seq_r, slot_add(bank_base, 3'h3));
	assign tog_match[4] = pix_r == fld(seq_r, slot_add(bank_base, 3'h4));
	assign tog_match[5] = pix_r == fld(seq_r, slot_add(bank_base, 3'h5));

	// pattern toggles one to four compare against the pattern position
	assign pat_match[0] = pos_cur == fld(seq_r, slot_add(`HBPG_SLOT_EVEN1, 3'h0));
	assign pat_match[1] = pos_cur == fld(seq_r, slot_add(`HBPG_SLOT_EVEN1, 3'h1));
	assign pat_match[2] = pos_cur == fld(seq_r, slot_add(`HBPG_SLOT_EVEN1, 3'h2));
	assign pat_match[3] = pos_cur == fld(seq_r, slot_add(`HBPG_SLOT_EVEN1, 3'h3));
	wire tog_hit = ^(tog_en & tog_match); // R1 R5 R18
	wire pat_hit = ^pat_match; // R13

	// repeat mode: window from start to end, pattern repeated inside it
	reg win_nxt;
	reg run_cur;
	reg run_nxt;
	reg pbit_cur;
	reg pbit_nxt;
	reg [`HBPG_POS_W-1:0] pos_nxt;
	reg [`HBPG_REP_W-1:0] cnt_cur;
	reg [`HBPG_REP_W-1:0] cnt_nxt;
	reg wrap;
	always @* begin
		win_nxt = at_line_start(pix_r) ? 1'b0 : win_r;
		run_cur = at_line_start(pix_r) ? 1'b0 : run_r;
		pbit_cur = pbit_r;
		cnt_cur = cnt_r;
		if (start_hit) begin
			win_nxt = 1'b1;
			run_cur = (rep_num != 8'h00) && (rep_len != 13'h0000); // R15
			pbit_cur = 1'b0;
			cnt_cur = 8'h00;
		end
		if (pix_r == rep_end)
			win_nxt = 1'b0; // R14
		// toggles act on the position within the pattern, not on the pixel
		pbit_nxt = pbit_cur ^ (run_cur & pat_hit);
		// the pattern restarts at each wrap until the repeat count runs out
		wrap = run_cur && (pos_cur == rep_len - 13'h0001);
		pos_nxt = wrap ? 13'h0000 : pos_cur + 13'h0001;
		cnt_nxt = wrap ? cnt_cur + 8'h01 : cnt_cur;
		run_nxt = run_cur & ~(wrap & (cnt_nxt == rep_num));
		if (wrap)
			pbit_nxt = 1'b0;
	end

	// blank state always restarts inactive at pixel zero
	wire blank_base = at_line_start(pix_r) ? 1'b0 : blank_r; // R18
	wire pbit_now = pbit_cur ^ (run_cur & pat_hit);
	wire rep_blank = win_nxt & ~pbit_now;

	reg blank_nxt;
	always @* begin
		if (!ctrl_en_r)
			blank_nxt = 1'b0;
		else if (repeat_mode)
			blank_nxt = rep_blank; // R13
		else
			blank_nxt = blank_base ^ tog_hit; // R5
	end

	// status word: pixel, line, blank, applied sequence, vertical hold allowed
	wire hold_allowed = alt != `HBPG_ALT_SPLIT; // R11
	wire [31:0] status_word = {3'h0, hold_allowed, seq_r, blank_r, line_r, pix_r};

	// read data is picked in the setup cycle so it stands through the access cycle
	reg [31:0] rd_word;
	always @* begin
		rd_word = 32'h00000000;
		if (!apb_err) begin
			if (in_bank) begin
				rd_word = {19'h00000, cfg_mem[mem_idx]};
			end else begin
				case (paddr)
				`HBPG_ADDR_CTRL: rd_word = {29'h00000000, ctrl_seq_r, ctrl_en_r};
				`HBPG_ADDR_LINE_LEN: rd_word = {19'h00000, line_len_r};
				`HBPG_ADDR_FIELD_LINES: rd_word = {20'h00000, field_lines_r};
				`HBPG_ADDR_STATUS: rd_word = status_word;
				default: rd_word = 32'h00000000;
				endcase
			end
		end
	end

	// apb registers and settings store
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// every slot, mask and alternation included, starts at the unused toggle value
			for (i = 0; i < MEM_DEPTH; i = i + 1)
				cfg_mem[i] <= `HBPG_TOG_RST;
			ctrl_en_r <= 1'b0;
			ctrl_seq_r <= 2'h0;
			line_len_r <= `HBPG_LINE_LEN_RST;
			field_lines_r <= `HBPG_FIELD_LINES_RST;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= apb_setup;
			pslverr <= apb_setup & apb_err;
			if (apb_setup)
				prdata <= rd_word;
			if (wr_bank) begin
				// narrow settings keep only their own width
				case (mem_idx[3:0])
				`HBPG_SLOT_MASK: cfg_mem[mem_idx] <= {12'h000, pwdata[0]}; // R2
				`HBPG_SLOT_ALT: cfg_mem[mem_idx] <= {10'h000, pwdata[2:0]}; // R7
				`HBPG_SLOT_REP: cfg_mem[mem_idx] <= {5'h00, pwdata[7:0]}; // R15
				default: cfg_mem[mem_idx] <= pwdata[`HBPG_POS_W-1:0]; // R6 R3
				endcase
			end
			// status is read only: a write to it is simply dropped
			if (wr_ctrl) begin
				ctrl_en_r <= pwdata[`HBPG_CTRL_EN];
				ctrl_seq_r <= pwdata[`HBPG_CTRL_SEQ_HI:`HBPG_CTRL_SEQ_LO];
			end
			if (wr_line_len)
				line_len_r <= pwdata[`HBPG_POS_W-1:0];
			if (wr_field_lines)
				field_lines_r <= pwdata[`HBPG_LINE_W-1:0];
		end
	end

	// pixel counter; it and the line counter hold at zero while disabled
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pix_r <= 13'h0000;
		end else if (!ctrl_en_r) begin
			pix_r <= 13'h0000;
		end else if (line_end) begin
			pix_r <= 13'h0000;
		end else begin
			pix_r <= pix_r + 13'h0001;
		end
	end

	// line counter and sequence; the sequence switches at a line boundary, or every cycle while disabled
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_r <= 12'h000;
			seq_r <= 2'h0;
		end else if (!ctrl_en_r) begin
			line_r <= 12'h000;
			seq_r <= ctrl_seq_r;
		end else if (line_end) begin
			seq_r <= ctrl_seq_r; // R3
			line_r <= field_end ? 12'h000 : line_r + 12'h001; // R17
		end
	end

	// line and field markers, one cycle after the counter showed pixel zero
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_start <= 1'b0;
			field_start <= 1'b0;
		end else begin
			line_start <= ctrl_en_r & at_line_start(pix_r);
			field_start <= ctrl_en_r & at_line_start(pix_r) & (line_r == 12'h000);
		end
	end

	// blanking state
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blank_r <= 1'b0;
			win_r <= 1'b0;
			run_r <= 1'b0;
			pbit_r <= 1'b0;
			pos_r <= 13'h0000;
			cnt_r <= 8'h00;
		end else begin
			blank_r <= blank_nxt;
			win_r <= win_nxt;
			run_r <= run_nxt;
			pbit_r <= pbit_nxt;
			pos_r <= pos_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// horizontal clock phases; disabled, phase_r sits low so one and three rest low
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_r <= 1'b0;
			line_blank <= 1'b0;
			hclk_phase_one <= 1'b0;
			hclk_phase_two <= 1'b1;
			hclk_phase_three <= 1'b0;
			hclk_phase_four <= 1'b1;
			last_stage_hclk <= 1'b0;
		end else begin
			line_blank <= blank_nxt;
			phase_r <= ctrl_en_r & ~phase_r;
			if (blank_nxt) begin
				// masked: the shift register is parked at the chosen level
				hclk_phase_one <= mask_pol; // R2
				hclk_phase_three <= mask_pol; // R2
				last_stage_hclk <= mask_pol; // R2
				hclk_phase_two <= ~mask_pol; // R16
				hclk_phase_four <= ~mask_pol; // R16
			end else begin
				hclk_phase_one <= phase_r;
				hclk_phase_three <= phase_r;
				last_stage_hclk <= phase_r;
				hclk_phase_two <= ~phase_r; // R16
				hclk_phase_four <= ~phase_r; // R16
			end
		end
	end

endmodule // hbpg_top

// ### bench/hbpg_ccd_model.sv
// behavioural model of the ccd horizontal shift register
`timescale 1ns/1ps
module hbpg_ccd_model (
	// phase clocks
	input wire hclk_phase_one,
	input wire hclk_phase_two,
	// transfer count
	output int shifts
);
	initial shifts = 0;
	// charge moves one cell per phase one rise, only with phase two opposite
	// phase two changes in the same step as phase one, so look once it has settled
	always @(posedge hclk_phase_one) begin
		#1;
		if (!hclk_phase_two)
			shifts <= shifts + 1;
	end
endmodule // hbpg_ccd_model

// ### bench/hbpg_checker.sv
// port assertions of the blanking generator
`timescale 1ns/1ps
module hbpg_checker (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb
	input wire psel,
	input wire penable,
	input wire pready,
	input wire pslverr,
	// ccd side
	input wire line_blank,
	input wire hclk_phase_one,
	input wire hclk_phase_two,
	input wire hclk_phase_three,
	input wire hclk_phase_four,
	input wire last_stage_hclk,
	input wire line_start,
	input wire field_start
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_inv2;
		hclk_phase_two == !hclk_phase_one;
	endproperty
	a_inv2: assert property (p_inv2) else $error("phase two not inverse");
	property p_inv4;
		hclk_phase_four == !hclk_phase_three;
	endproperty
	a_inv4: assert property (p_inv4) else $error("phase four not inverse");
	property p_park;
		line_blank && $past(line_blank) && $past(line_blank, 2) |-> $stable(hclk_phase_one)
			&& hclk_phase_three == hclk_phase_one && last_stage_hclk == hclk_phase_one;
	endproperty
	a_park: assert property (p_park) else $error("phases not parked in blank");
	property p_rdy;
		psel && !penable |=> pready;
	endproperty
	a_rdy: assert property (p_rdy) else $error("no ready after setup");
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
	property p_err;
		pslverr |-> pready;
	endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_field;
		field_start |-> line_start;
	endproperty
	a_field: assert property (p_field) else $error("field start off line start");
	property p_lsgap;
		line_start |=> !line_start [*3];
	endproperty
	a_lsgap: assert property (p_lsgap) else $error("line start too close");
endmodule // hbpg_checker
bind hbpg_top hbpg_checker chk_i (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
	.line_blank, .hclk_phase_one, .hclk_phase_two, .hclk_phase_three, .hclk_phase_four,
	.last_stage_hclk, .line_start, .field_start);

// ### bench/horizontal_blank_pattern_gen_test.sv
// self-checking bench of the blanking generator
`timescale 1ns/1ps
`include "hbpg_defines.vh"
module horizontal_blank_pattern_gen_test;
	localparam int L = 24;
	localparam int NL = 4;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, x = 58;
	logic pready, pslverr, line_blank, ph1, ph2, ph3, ph4, phl, line_start, field_start;
	int num_errors = 0, checks = 0, mode, mask, seq, i, l, p;
	int tg[1:6], to[1:6];
	hbpg_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .line_blank, .hclk_phase_one(ph1), .hclk_phase_two(ph2),
		.hclk_phase_three(ph3), .hclk_phase_four(ph4), .last_stage_hclk(phl),
		.line_start, .field_start);
	hbpg_ccd_model ccd (.hclk_phase_one(ph1), .hclk_phase_two(ph2), .shifts());
	initial forever #50 pclk = ~pclk;
	function int rnd();
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x[15:0];
	endfunction
	function logic ex(int p, int l);
		logic b;
		int t;
		b = 0;
		if (mode >= 4)
			return p >= tg[5] && p < tg[6];
		for (int k = 1; k <= 6; k++) begin
			t = (mode == 3 && l % 2) ? to[k] : tg[k];
			if ((mode == 0 || mode == 3 || (mode == 1) == ((l % 2 == 1) == (k < 3))) && t <= p)
				b = ~b;
		end
		return b;
	endfunction
	task chk(string n, logic [31:0] e, logic [31:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task apb(logic w, int a, int d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a[11:0];
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task complete_run;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#3000000;
		num_errors++;
		complete_run;
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		apb(0, `HBPG_ADDR_LINE_LEN, 0);
		chk("line_len", 32'h800, rd);
		apb(0, `HBPG_ADDR_FIELD_LINES, 0);
		chk("field_lines", 32'h100, rd);
		apb(0, 8, 0);
		chk("toggle_rst", 32'h1FFD, rd);
		apb(0, 12'h110, 0);
		chk("unmapped", 1, er);
		apb(1, 12'h102, 5);
		chk("unaligned", 1, er);
		apb(1, `HBPG_ADDR_LINE_LEN, L);
		apb(1, `HBPG_ADDR_FIELD_LINES, NL);
		for (int r = 0; r < 16; r++) begin
			mode = r % 8;
			mask = rnd() % 2;
			seq = rnd() % 4;
			apb(1, `HBPG_ADDR_CTRL, 0);
			for (i = 1; i <= 6; i++) begin
				tg[i] = 3 * i + rnd() % 3;
				to[i] = 3 * i + rnd() % 3;
				if (r > 7 && i > 4 && mode < 4)
					tg[i] = 8189;
				apb(1, seq * 64 + 4 * (1 + i), tg[i]);
				apb(1, seq * 64 + 4 * (9 + i), to[i]);
				apb(1, (seq ^ 1) * 64 + 4 * (1 + i), i);
			end
			apb(1, (seq ^ 1) * 64 + 4, 0);
			apb(1, seq * 64, mask);
			apb(1, seq * 64 + 32, 0);
			apb(1, seq * 64 + 36, 0);
			apb(1, seq * 64 + 4, mode);
			apb(0, seq * 64 + 4, 0);
			chk("alt", mode, rd);
			apb(1, `HBPG_ADDR_CTRL, seq * 2 + 1);
			repeat (2) begin
				@(negedge pclk);
				for (i = 0; field_start !== 1'b1 && i < 500; i++) @(negedge pclk);
			end
			chk("field_start", 1, field_start);
			for (l = 0; l < NL; l++) begin
				for (p = 0; p < L; p++) begin
					if (p == 0)
						chk("line_start", 1, line_start);
					chk("line_blank", ex(p, l), line_blank);
					if (p > 1 && ex(p, l) && ex(p - 1, l) && ex(p - 2, l)) begin
						chk("ph1", mask, ph1);
						chk("ph3", mask, ph3);
						chk("phl", mask, phl);
					end
					@(negedge pclk);
				end
			end
			apb(0, `HBPG_ADDR_STATUS, 0);
			chk("hold_allowed", mode != 3, rd[28]);
		end
		chk("shifted", 1, ccd.shifts > 0);
		complete_run;
	end
endmodule // horizontal_blank_pattern_gen_test
